// [scf_pkg.sv]
// Shared constants, types and states of the serial command frame responder
// Operation
// RL1: Serial link runs at 9600 bits per second both ways.
// RL2: Each character: one start bit, eight data bits, no parity, one stop.
// RL3: Host keeps XON/XOFF flow control switched off.
// RL4: Frame bytes: start, address, command, length, header check, payload, payload check.
// RL5: Command code is exactly three bytes at positions 2 to 4.
// RL6: A valid frame is 7 to 82 bytes long.
// RL7: Every frame ends with a single 0x00 byte.
// RL8: Bytes go out in order from byte 0, back to back, no handshake.
// RL9: Start code 0x07 command, 0x06 acknowledge, 0x15 negative acknowledge.
// RL10: Reply acknowledge on success, negative acknowledge on failure.
// RL11: Not understood, invalid or unsupported commands get negative acknowledge.
// RL12: Negative acknowledge echoes the received data.
// RL13: Frames not starting with the command code are silently dropped.
// RL14: Reply address byte names the responding unit.
// RL15: Broadcast address 0xFF is accepted by every unit.
// RL16: Addresses 0x00 to 0xFE select one unit each.
// RL17: Own address is 0x00 after reset until reconfigured.
// RL18: On point-to-point links the host sends address 0xFF.
// RL19: Payload length lies between 0 and 74.
// RL20: Network carries identical frames over TCP port 10001.
// RL21: Network and single-ended serial run together; differential modes never both.
// RL22: Handshake lines are only looped back, no real flow control.
// RL23: Header bytes 0 to 6 sum to 0xFF, else negative acknowledge without payload.
// RL24: Payload bytes plus check sum to 0xFF, else negative acknowledge.
// RL25: Only the addressed unit answers a directed frame, at once.
// RL26: Broadcast reply waits (2.5 byte periods plus reply length) times own address.
// RL27: Oversized length or frame is invalid and gets negative acknowledge.
package scf_pkg;

    localparam int CLK_HZ = 25_000_000;
    localparam int BAUD_RATE = 9600;
    localparam int BIT_CYC = CLK_HZ / BAUD_RATE;
    localparam logic [11:0] BIT_RELOAD = 12'(BIT_CYC - 1);
    localparam logic [11:0] HALF_RELOAD = 12'(BIT_CYC / 2 - 1);
    localparam logic [3:0] STOP_BIT = 4'h9;
    localparam logic [9:0] CHAR_BITS = 10'h00a;
    localparam logic [9:0] TR_BITS = 10'h019;
    localparam int NET_PORT = 10001;

    localparam logic [7:0] CODE_CMD = 8'h07;
    localparam logic [7:0] CODE_ACK = 8'h06;
    localparam logic [7:0] CODE_NAK = 8'h15;
    localparam logic [7:0] ADDR_BCAST = 8'hff;
    localparam logic [7:0] ADDR_RESET = 8'h00;
    localparam logic [7:0] TERM_BYTE = 8'h00;
    localparam logic [7:0] SUM_GOOD = 8'hff;
    localparam logic [7:0] MAX_PAYLOAD = 8'h4a;

    localparam int MAX_FRAME = 82;
    localparam logic [6:0] POS_ADDR = 7'h01;
    localparam logic [6:0] POS_LEN = 7'h05;
    localparam logic [6:0] POS_HCHK = 7'h06;
    localparam logic [6:0] POS_PAY = 7'h07;
    localparam logic [6:0] SHORT_REPLY = 7'h08;
    localparam int FIFO_DEPTH = 4;

    localparam logic [1:0] MODE_SINGLE = 2'h0;
    localparam logic [1:0] MODE_FOUR_WIRE = 2'h1;
    localparam logic [1:0] MODE_TWO_WIRE = 2'h2;

    typedef struct packed {
        logic [23:0] code;
        logic [7:0] addr;
        logic [7:0] len;
    } scf_cmd_s;

    typedef enum logic [7:0] {
        S_IDLE = 8'h01,
        S_HDR = 8'h02,
        S_PAY = 8'h04,
        S_TERM = 8'h08,
        S_DROP = 8'h10,
        S_EXEC = 8'h20,
        S_WAIT = 8'h40,
        S_SEND = 8'h80
    } scf_state_e;

endpackage

// [scf_responder.sv]
// Frame responder with serial and network byte paths, plus its receive FIFO
`timescale 1ns/1ps
`default_nettype none

module scf_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [AW:0] wrPtr_q;
    logic [AW:0] rdPtr_q;
    logic full;
    logic empty;

    assign empty = wrPtr_q == rdPtr_q;
    assign full = (wrPtr_q[AW] != rdPtr_q[AW]) && (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]);
    assign inReady = !full;
    assign outValid = !empty;
    assign outData = mem[rdPtr_q[AW-1:0]];

    always_ff @(posedge clk) begin
        if (inValid && !full) begin
            mem[wrPtr_q[AW-1:0]] <= inData;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
        end else begin
            if (inValid && !full) begin
                wrPtr_q <= wrPtr_q + 1'b1;
            end
            if (outReady && !empty) begin
                rdPtr_q <= rdPtr_q + 1'b1;
            end
        end
    end
endmodule

module scf_responder
    import scf_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic rxd,
    output logic txd,
    output logic txDrvEn,
    input wire logic rtsIn,
    output logic ctsOut,
    input wire logic [1:0] portMode,
    input wire logic [7:0] unitAddr,
    input wire logic unitAddrLoad,
    input wire logic netRxValid,
    input wire logic [7:0] netRxData,
    output logic netRxReady,
    output logic netTxValid,
    output logic [7:0] netTxData,
    input wire logic netTxReady,
    output logic cmdValid,
    output scf_cmd_s cmdInfo,
    input wire logic [6:0] cmdRdIdx,
    output logic [7:0] cmdRdData,
    input wire logic cmdDone,
    input wire logic cmdOk,
    output logic rxOverrun,
    output logic busy
);
    scf_state_e state_q;
    logic [7:0] frame [0:MAX_FRAME-1];
    logic [7:0] myAddr_q;
    logic [11:0] divCnt_q;
    logic bitTick;
    logic rxBusy_q, rxValid_q, rxdEff;
    logic [11:0] rxCnt_q;
    logic [3:0] rxBit_q;
    logic [7:0] rxShift_q;
    logic fifoInReady, fifoOutValid, fifoOutReady;
    logic [7:0] fifoOutData;
    logic txBusy_q, txd_q, txLoad;
    logic [11:0] txCnt_q;
    logic [3:0] txBit_q;
    logic [9:0] txShift_q;
    logic srcNet_q, curNet, inValid, inReady, take;
    logic [7:0] inData;
    logic [6:0] idx_q;
    logic [7:0] hSum_q, pSum_q, len_q, hSumNext, pSumNext, replyCode_q;
    logic match_q, bcast_q, nakShort_q, netTxValid_q;
    logic [7:0] netTxData_q;
    logic [6:0] replyLen;
    logic [17:0] delay_q, delayLoad;
    logic [9:0] perUnit;
    logic [7:0] sendByte, replyChk;
    logic outReady, sendFire;

    // Own address, broadcast-safe default after reset [RL17] [RL16]
    always_ff @(posedge clk) begin
        if (rst) begin
            myAddr_q <= ADDR_RESET;
        end else if (unitAddrLoad && unitAddr != ADDR_BCAST) begin
            myAddr_q <= unitAddr;
        end
    end

    // Handshake lines looped back only [RL22]
    always_ff @(posedge clk) begin
        if (rst) begin
            ctsOut <= 1'b0;
        end else begin
            ctsOut <= rtsIn;
        end
    end

    // Free bit-period divider for reply spacing
    assign bitTick = divCnt_q == '0;
    always_ff @(posedge clk) begin
        if (rst || bitTick) begin
            divCnt_q <= BIT_RELOAD;
        end else begin
            divCnt_q <= divCnt_q - 1'b1;
        end
    end

    // Two-wire half duplex hears its own echo, so mask it [RL21]
    assign rxdEff = (portMode == MODE_TWO_WIRE && txBusy_q) ? 1'b1 : rxd;

    // Serial receiver, mid-bit sampling [RL1] [RL2]
    always_ff @(posedge clk) begin
        if (rst) begin
            rxBusy_q <= 1'b0;
            rxCnt_q <= '0;
            rxBit_q <= '0;
            rxShift_q <= '0;
            rxValid_q <= 1'b0;
        end else begin
            rxValid_q <= 1'b0;
            if (!rxBusy_q) begin
                if (!rxdEff) begin
                    rxBusy_q <= 1'b1;
                    rxCnt_q <= HALF_RELOAD;
                    rxBit_q <= '0;
                end
            end else if (rxCnt_q != '0) begin
                rxCnt_q <= rxCnt_q - 1'b1;
            end else begin
                rxCnt_q <= BIT_RELOAD;
                rxBit_q <= rxBit_q + 1'b1;
                if (rxBit_q == '0 && rxdEff) begin
                    rxBusy_q <= 1'b0;
                end else if (rxBit_q == STOP_BIT) begin
                    rxBusy_q <= 1'b0;
                    rxValid_q <= rxdEff;
                end else if (rxBit_q != '0) begin
                    rxShift_q <= {rxdEff, rxShift_q[7:1]};
                end
            end
        end
    end

    assign rxOverrun = rxValid_q && !fifoInReady;

    scf_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) rxFifo (
        .clk(clk),
        .rst(rst),
        .inValid(rxValid_q),
        .inReady(fifoInReady),
        .inData(rxShift_q),
        .outValid(fifoOutValid),
        .outReady(fifoOutReady),
        .outData(fifoOutData)
    );

    // Serial transmitter, 8N1 [RL1] [RL2]
    always_ff @(posedge clk) begin
        if (rst) begin
            txBusy_q <= 1'b0;
            txd_q <= 1'b1;
            txCnt_q <= '0;
            txBit_q <= '0;
            txShift_q <= '1;
        end else if (!txBusy_q) begin
            if (txLoad) begin
                txShift_q <= {1'b1, sendByte, 1'b0};
                txd_q <= 1'b0;
                txBusy_q <= 1'b1;
                txCnt_q <= BIT_RELOAD;
                txBit_q <= '0;
            end
        end else if (txCnt_q != '0) begin
            txCnt_q <= txCnt_q - 1'b1;
        end else if (txBit_q == STOP_BIT) begin
            txBusy_q <= 1'b0;
        end else begin
            txd_q <= txShift_q[1];
            txShift_q <= {1'b1, txShift_q[9:1]};
            txBit_q <= txBit_q + 1'b1;
            txCnt_q <= BIT_RELOAD;
        end
    end

    assign txd = txd_q;
    // Only one differential driver mode is ever selected [RL21]
    always_ff @(posedge clk) begin
        if (rst) begin
            txDrvEn <= 1'b0;
        end else begin
            txDrvEn <= (portMode != MODE_SINGLE) && (txBusy_q || txLoad);
        end
    end

    // Source pick: a frame owns its path until the reply is sent [RL20] [RL21]
    assign curNet = (state_q == S_IDLE) ? !fifoOutValid : srcNet_q;
    assign inValid = curNet ? netRxValid : fifoOutValid;
    assign inData = curNet ? netRxData : fifoOutData;
    assign inReady = state_q inside {S_IDLE, S_HDR, S_PAY, S_TERM, S_DROP};
    assign take = inValid && inReady;
    assign fifoOutReady = inReady && !curNet;
    assign netRxReady = inReady && curNet;

    assign hSumNext = hSum_q + inData;
    assign pSumNext = pSum_q + inData;

    // Receive buffer, byte positions follow the frame layout [RL4] [RL5]
    always_ff @(posedge clk) begin
        if (take && (state_q inside {S_IDLE, S_HDR, S_PAY}) && idx_q < 7'(MAX_FRAME)) begin
            frame[idx_q] <= inData;
        end
    end

    always_ff @(posedge clk) begin
        cmdRdData <= frame[cmdRdIdx];
    end

    // Reply length, short form for header or size faults [RL6] [RL23]
    assign replyLen = (nakShort_q || len_q == '0) ? SHORT_REPLY : 7'(len_q) + 7'h09;
    assign perUnit = TR_BITS + CHAR_BITS * 10'(replyLen);
    assign delayLoad = bcast_q ? 18'(perUnit) * 18'(myAddr_q) : '0; // [RL26]

    // Reply header checksum over outgoing bytes 0 to 5 [RL23]
    always_comb begin
        replyChk = replyCode_q + myAddr_q + frame[2] + frame[3] + frame[4];
        replyChk = ~(replyChk + (nakShort_q ? 8'h00 : len_q));
    end

    // Outgoing byte for the current position; echo of received data [RL12] [RL14]
    always_comb begin
        if (idx_q == replyLen - 1'b1) begin
            sendByte = TERM_BYTE; // [RL7]
        end else if (idx_q == '0) begin
            sendByte = replyCode_q; // [RL9]
        end else if (idx_q == POS_ADDR) begin
            sendByte = myAddr_q;
        end else if (idx_q == POS_LEN) begin
            sendByte = nakShort_q ? 8'h00 : len_q;
        end else if (idx_q == POS_HCHK) begin
            sendByte = replyChk;
        end else begin
            sendByte = frame[idx_q];
        end
    end

    // Bytes go out back to back as soon as the sink takes them [RL8]
    assign outReady = srcNet_q ? (!netTxValid_q || netTxReady) : !txBusy_q;
    assign sendFire = (state_q == S_SEND) && outReady;
    assign txLoad = sendFire && !srcNet_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            netTxValid_q <= 1'b0;
            netTxData_q <= '0;
        end else if (sendFire && srcNet_q) begin
            netTxValid_q <= 1'b1;
            netTxData_q <= sendByte;
        end else if (netTxReady) begin
            netTxValid_q <= 1'b0;
        end
    end

    assign netTxValid = netTxValid_q;
    assign netTxData = netTxData_q;
    assign busy = state_q != S_IDLE;

    // Frame engine
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= S_IDLE;
            srcNet_q <= 1'b0;
            idx_q <= '0;
            hSum_q <= '0;
            pSum_q <= '0;
            len_q <= '0;
            match_q <= 1'b0;
            bcast_q <= 1'b0;
            nakShort_q <= 1'b0;
            replyCode_q <= CODE_NAK;
            delay_q <= '0;
            cmdValid <= 1'b0;
            cmdInfo <= '0;
        end else begin
            cmdValid <= 1'b0;
            case (state_q)
                S_IDLE: begin
                    if (take && inData == CODE_CMD) begin // [RL13]
                        state_q <= S_HDR;
                        srcNet_q <= curNet;
                        hSum_q <= inData;
                        idx_q <= POS_ADDR;
                        nakShort_q <= 1'b0;
                    end
                end
                S_HDR: begin
                    if (take) begin
                        hSum_q <= hSumNext;
                        idx_q <= idx_q + 1'b1;
                        if (idx_q == POS_ADDR) begin
                            match_q <= inData == myAddr_q || inData == ADDR_BCAST; // [RL15] [RL25]
                            bcast_q <= inData == ADDR_BCAST;
                        end
                        if (idx_q == POS_LEN) begin
                            len_q <= inData;
                        end
                        if (idx_q == POS_HCHK) begin
                            pSum_q <= '0;
                            if (hSumNext != SUM_GOOD || len_q > MAX_PAYLOAD) begin
                                state_q <= S_DROP; // [RL23] [RL19] [RL27]
                                nakShort_q <= 1'b1;
                            end else begin
                                state_q <= (len_q == '0) ? S_TERM : S_PAY;
                            end
                        end
                    end
                end
                S_PAY: begin
                    if (take) begin
                        pSum_q <= pSumNext;
                        idx_q <= idx_q + 1'b1;
                        if (idx_q == POS_PAY + 7'(len_q)) begin
                            state_q <= S_TERM;
                        end
                    end
                end
                S_TERM: begin
                    if (take) begin
                        idx_q <= '0;
                        if (inData != TERM_BYTE) begin
                            state_q <= S_DROP; // [RL7] [RL27]
                            nakShort_q <= 1'b1;
                        end else if (!match_q) begin
                            state_q <= S_IDLE; // [RL25]
                        end else if (len_q != '0 && pSum_q != SUM_GOOD) begin
                            state_q <= S_WAIT; // [RL24]
                            replyCode_q <= CODE_NAK;
                        end else begin
                            state_q <= S_EXEC;
                            cmdValid <= 1'b1;
                            cmdInfo <= '{code: {frame[2], frame[3], frame[4]},
                                         addr: frame[1], len: len_q};
                        end
                    end
                end
                S_DROP: begin
                    if (take && inData == TERM_BYTE) begin
                        idx_q <= '0;
                        replyCode_q <= CODE_NAK;
                        state_q <= match_q ? S_WAIT : S_IDLE;
                    end
                end
                S_EXEC: begin
                    if (cmdDone) begin // [RL10] [RL11]
                        replyCode_q <= cmdOk ? CODE_ACK : CODE_NAK;
                        state_q <= S_WAIT;
                    end
                end
                S_WAIT: begin
                    delay_q <= delayLoad;
                    state_q <= (delayLoad == '0) ? S_SEND : S_WAIT;
                    if (delay_q != '0) begin
                        delay_q <= bitTick ? delay_q - 1'b1 : delay_q;
                        state_q <= (delay_q == 18'h00001 && bitTick) ? S_SEND : S_WAIT;
                    end
                end
                S_SEND: begin
                    if (sendFire) begin
                        idx_q <= idx_q + 1'b1;
                        if (idx_q == replyLen - 1'b1) begin
                            state_q <= S_IDLE;
                            idx_q <= '0;
                        end
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

    property p_term;
        @(posedge clk) disable iff (rst)
        netTxValid_q && !busy |-> netTxData_q == TERM_BYTE;
    endproperty
    a_term: assert property (p_term) else $error("reply not ended by null"); // [RL7]

    property p_bit_time;
        @(posedge clk) disable iff (rst)
        txBusy_q && $changed(txd_q) |-> txCnt_q == BIT_RELOAD;
    endproperty
    a_bit_time: assert property (p_bit_time) else $error("bit period wrong"); // [RL1]

    property p_stop_bit;
        @(posedge clk) disable iff (rst)
        txBusy_q && txBit_q == STOP_BIT |-> txd_q;
    endproperty
    a_stop_bit: assert property (p_stop_bit) else $error("stop bit not high"); // [RL2]

    property p_drop;
        @(posedge clk) disable iff (rst)
        state_q == S_IDLE && take && inData != CODE_CMD |=> state_q == S_IDLE;
    endproperty
    a_drop: assert property (p_drop) else $error("non-command frame accepted"); // [RL13]

    property p_code;
        @(posedge clk) disable iff (rst)
        sendFire && idx_q == '0 |-> sendByte == CODE_ACK || sendByte == CODE_NAK;
    endproperty
    a_code: assert property (p_code) else $error("bad reply start code"); // [RL9]

    property p_hdr_bad;
        @(posedge clk) disable iff (rst)
        state_q == S_HDR && take && idx_q == POS_HCHK && hSumNext != SUM_GOOD
            |=> state_q == S_DROP && nakShort_q;
    endproperty
    a_hdr_bad: assert property (p_hdr_bad) else $error("header fault not caught"); // [RL23]

    property p_reset_addr;
        @(posedge clk) $past(rst) |-> myAddr_q == ADDR_RESET;
    endproperty
    a_reset_addr: assert property (p_reset_addr) else $error("address not reset"); // [RL17]

    property p_reply_addr;
        @(posedge clk) disable iff (rst)
        sendFire && idx_q == POS_ADDR |-> sendByte == myAddr_q;
    endproperty
    a_reply_addr: assert property (p_reply_addr) else $error("reply address wrong"); // [RL14]

    property p_loop;
        @(posedge clk) disable iff (rst)
        !$past(rst) |-> ctsOut == $past(rtsIn);
    endproperty
    a_loop: assert property (p_loop) else $error("handshake not looped"); // [RL22]

    property p_direct;
        @(posedge clk) disable iff (rst)
        state_q == S_WAIT && !bcast_q |=> state_q == S_SEND;
    endproperty
    a_direct: assert property (p_direct) else $error("directed reply delayed"); // [RL25]

endmodule

`default_nettype wire

// [scf_host_model.sv]
// Host model: network frame source and reply sink
`timescale 1ns/1ps
`default_nettype none

module scf_host_model (
    input wire logic clk,
    input wire logic rst,
    output logic rxValid,
    output logic [7:0] rxData,
    input wire logic rxReady,
    input wire logic txValid,
    input wire logic [7:0] txData,
    output logic txReady
);
    logic [7:0] got[$];

    initial begin
        rxValid = 1'b0;
        rxData = 8'h00;
        txReady = 1'b0;
    end

    // Reply sink stalls every other cycle
    always @(posedge clk) txReady <= rst ? 1'b0 : !txReady;

    always @(negedge clk) if (txValid && txReady) got.push_back(txData);

    // Byte 0 first, rest back to back, no flow-control bytes
    task automatic send(input logic [7:0] f[$]);
        foreach (f[i]) begin
            @(posedge clk);
            rxValid <= 1'b1;
            rxData <= f[i];
            do @(negedge clk); while (rxReady !== 1'b1);
        end
        @(posedge clk);
        rxValid <= 1'b0;
        rxData <= ~rxData;
    endtask
endmodule

`default_nettype wire

// [scf_responder_bench.sv]
// Self-checking bench for the frame responder
`timescale 1ns/1ps
`default_nettype none

module scf_responder_bench;
    import scf_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic rtsIn = 1'b0;
    logic cmdDone = 1'b0;
    logic cmdOk = 1'b0;
    logic rxd = 1'b1;
    logic unitAddrLoad = 1'b0;
    logic [7:0] unitAddr = 8'h00;
    logic [6:0] cmdRdIdx = 7'h00;
    logic txd, txDrvEn, ctsOut, netRxValid, netRxReady, netTxValid, netTxReady;
    logic cmdValid, rxOverrun, busy;
    logic [7:0] netRxData, netTxData, cmdRdData;
    scf_cmd_s cmdInfo;
    int miscompares = 0;
    int comparisons = 0;
    int cycles = 0;

    always #20 clk = ~clk;

    scf_responder u_dut (.clk(clk), .rst(rst), .rxd(rxd), .txd(txd), .txDrvEn(txDrvEn),
        .rtsIn(rtsIn), .ctsOut(ctsOut), .portMode(MODE_SINGLE), .unitAddr(unitAddr),
        .unitAddrLoad(unitAddrLoad), .netRxValid(netRxValid), .netRxData(netRxData),
        .netRxReady(netRxReady), .netTxValid(netTxValid), .netTxData(netTxData),
        .netTxReady(netTxReady), .cmdValid(cmdValid), .cmdInfo(cmdInfo),
        .cmdRdIdx(cmdRdIdx), .cmdRdData(cmdRdData), .cmdDone(cmdDone), .cmdOk(cmdOk),
        .rxOverrun(rxOverrun), .busy(busy));

    scf_host_model u_host (.clk(clk), .rst(rst), .rxValid(netRxValid), .rxData(netRxData),
        .rxReady(netRxReady), .txValid(netTxValid), .txData(netTxData), .txReady(netTxReady));

    task automatic end_sim();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            miscompares++;
            end_sim();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [7:0] inv_sum(input logic [7:0] f[$], input int a, input int b);
        logic [7:0] s;
        s = 8'h00;
        for (int i = a; i <= b; i++) s += f[i];
        return ~s;
    endfunction

    // Frame with command code 0x42 0x52 0x54 and np payload bytes
    function automatic void mk(output logic [7:0] f[$], input logic [7:0] st, input logic [7:0] ad,
            input logic [7:0] ln, input int np);
        f = {st, ad, 8'h42, 8'h52, 8'h54, ln};
        f.push_back(inv_sum(f, 0, 5));
        for (int i = 0; i < np; i++) f.push_back(8'h30 + 8'(i));
        if (np > 0) f.push_back(inv_sum(f, 7, 6 + np));
        f.push_back(8'h00);
    endfunction

    task automatic xfer(input string name, input logic [7:0] f[$], input logic [7:0] e[$],
            input logic ok, input int expCmd);
        int seen;
        seen = 0;
        u_host.got.delete();
        @(posedge clk);
        cmdOk <= ok;
        fork
            u_host.send(f);
            repeat (f.size() * 2 + 400) begin
                @(negedge clk);
                if (cmdValid === 1'b1) begin
                    seen++;
                    check("cmdCode", 32'(cmdInfo.code), 32'h425254);
                    check("cmdLen", 32'(cmdInfo.len), 32'(f[5]));
                    @(posedge clk);
                    cmdDone <= 1'b1;
                    @(posedge clk);
                    cmdDone <= 1'b0;
                end
            end
        join
        check("cmdValid", 32'(seen), 32'(expCmd));
        check("replyLen", 32'(u_host.got.size()), 32'(e.size()));
        foreach (e[i]) check("reply", 32'(u_host.got[i]), 32'(e[i]));
        $display("done %s", name);
    endtask

    task automatic t_serial();
        logic [9:0] sh;
        sh = {1'b1, 8'h5a, 1'b0};
        check("txdIdle", 32'(txd), 32'h1);
        check("drvIdle", 32'(txDrvEn), 32'h0);
        check("busyIdle", 32'(busy), 32'h0);
        @(posedge clk);
        rtsIn <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        check("ctsLoop", 32'(ctsOut), 32'h1);
        // One 8N1 character, LSB first, lands in buffer byte 0 and is dropped
        @(posedge clk);
        for (int i = 0; i < 10; i++) begin
            rxd <= sh[i];
            repeat (BIT_CYC) @(posedge clk);
        end
        check("rxByte", 32'(cmdRdData), 32'h5a);
        check("overrun", 32'(rxOverrun), 32'h0);
        check("rxIdle", 32'(busy), 32'h0);
        $display("done serial");
    endtask

    task automatic t_addr();
        logic [7:0] f[$], e[$];
        @(posedge clk);
        unitAddr <= 8'h02;
        unitAddrLoad <= 1'b1;
        @(posedge clk);
        unitAddrLoad <= 1'b0;
        mk(f, CODE_CMD, 8'h00, 8'h00, 0);
        xfer("oldAddr", f, e, 1'b1, 0);
        mk(f, CODE_CMD, 8'h02, 8'h00, 0);
        mk(e, CODE_ACK, 8'h02, 8'h00, 0);
        xfer("ownAddr", f, e, 1'b1, 1);
        cmdRdIdx <= 7'h04;
        repeat (2) @(posedge clk);
        #1;
        check("bufCode", 32'(cmdRdData), 32'h54);
    endtask

    task automatic t_ack();
        logic [7:0] f[$], e[$];
        mk(f, CODE_CMD, 8'h00, 8'h00, 0);
        mk(e, CODE_ACK, ADDR_RESET, 8'h00, 0);
        xfer("ack", f, e, 1'b1, 1);
    endtask

    task automatic t_nak_echo();
        logic [7:0] f[$], e[$];
        mk(f, CODE_CMD, ADDR_BCAST, 8'h02, 2);
        mk(e, CODE_NAK, ADDR_RESET, 8'h02, 2);
        xfer("nakEcho", f, e, 1'b0, 1);
    endtask

    task automatic t_max();
        logic [7:0] f[$], e[$];
        mk(f, CODE_CMD, 8'h00, MAX_PAYLOAD, 74);
        mk(e, CODE_ACK, ADDR_RESET, MAX_PAYLOAD, 74);
        xfer("maxFrame", f, e, 1'b1, 1);
    endtask

    task automatic t_silent();
        logic [7:0] f[$], e[$];
        mk(f, 8'h08, 8'h00, 8'h00, 0);
        xfer("badStart", f, e, 1'b1, 0);
        mk(f, CODE_CMD, 8'h05, 8'h00, 0);
        xfer("otherAddr", f, e, 1'b1, 0);
    endtask

    task automatic t_bad_hdr();
        logic [7:0] f[$], e[$];
        mk(f, CODE_CMD, 8'h00, 8'h00, 0);
        f[6] = f[6] ^ 8'h01;
        mk(e, CODE_NAK, ADDR_RESET, 8'h00, 0);
        xfer("badHeader", f, e, 1'b1, 0);
    endtask

    task automatic t_bad_pay();
        logic [7:0] f[$], e[$];
        mk(f, CODE_CMD, 8'h00, 8'h01, 1);
        f[8] = f[8] ^ 8'h01;
        mk(e, CODE_NAK, ADDR_RESET, 8'h01, 1);
        e[8] = f[8];
        xfer("badPayload", f, e, 1'b1, 0);
    endtask

    task automatic t_too_long();
        logic [7:0] f[$], e[$];
        mk(f, CODE_CMD, 8'h00, 8'h4b, 0);
        mk(e, CODE_NAK, ADDR_RESET, 8'h00, 0);
        xfer("tooLong", f, e, 1'b1, 0);
    endtask

    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_serial();
        t_ack();
        t_nak_echo();
        t_max();
        t_silent();
        t_bad_hdr();
        t_bad_pay();
        t_too_long();
        t_addr();
        end_sim();
    end
endmodule

`default_nettype wire
